// ---- serial_config_shift_latch.sv ----
// serial configuration shift register, latch and output clock stand-in
`timescale 1ns/1ps
`default_nettype none

// divides the reference by counting its edges
module bank_divider (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    // control
    input  wire logic       ref_edge_in,
    input  wire logic       bypass_in,
    input  wire logic       ref_level_in,
    input  wire logic [4:0] divide_in,
    // result
    output logic            clk_out
);
    logic [4:0] cnt_q;
    logic       div_q;
    wire  [4:0] div_eff = (divide_in < cfg_loader_pkg::DIV_MIN)
                          ? cfg_loader_pkg::DIV_MIN : divide_in;
    wire        wrap    = (cnt_q >= div_eff - 5'h01);

    // toggle every divide reference edges: period is divide ref periods
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= 5'h00;
            div_q <= 1'b0;
        end else if (ref_edge_in) begin
            cnt_q <= wrap ? 5'h00 : cnt_q + 5'h01;
            div_q <= wrap ? ~div_q : div_q;
        end
    end
    assign clk_out = bypass_in ? ref_level_in : div_q;
endmodule // bank_divider

module serial_config_shift_latch #(
    parameter int LOCK_CYCLES_P = cfg_loader_pkg::LOCK_CYCLES
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    // serial port pins
    input  wire logic        serial_shift_clock_in,
    input  wire logic        serial_data_in,
    input  wire logic        load_strobe_in,
    input  wire logic        output_enable_in,
    input  wire logic        reference_in,
    // output clocks and their enable
    output logic [3:0]       bank_a_clocks_out,
    output logic [3:0]       bank_b_clocks_out,
    output logic             reference_copy_output_out,
    output logic             clocks_oe_out,
    // decoded configuration
    output logic [11:0]      pll_mult_out,
    output logic [10:0]      pll_div_out,
    output logic [4:0]       bank_a_div_out,
    output logic [4:0]       bank_b_div_out,
    output logic             ss_rate_120k_out,
    output logic             configured_out,
    output logic             locked_out
);
    localparam int W = cfg_loader_pkg::WORD_BITS;

    // two-stage synchronisers plus one history stage for edges
    logic [4:0] s1_q, s2_q;
    logic       sck_h_q, stb_h_q, ref_h_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // strobe idles high on its pull-up: no false rise after reset
            s1_q    <= 5'h04;
            s2_q    <= 5'h04;
            sck_h_q <= 1'b0;
            stb_h_q <= 1'b1;
            ref_h_q <= 1'b0;
        end else begin
            s1_q    <= {reference_in, output_enable_in, load_strobe_in,
                        serial_data_in, serial_shift_clock_in};
            s2_q    <= s1_q;
            sck_h_q <= s2_q[0];
            stb_h_q <= s2_q[2];
            ref_h_q <= s2_q[4];
        end
    end
    wire sck_s   = s2_q[0];
    wire data_s  = s2_q[1];
    wire stb_s   = s2_q[2];
    wire oe_s    = s2_q[3];
    wire ref_s   = s2_q[4];
    wire sck_rise = sck_s & ~sck_h_q;
    wire stb_rise = stb_s & ~stb_h_q;
    wire ref_edge = ref_s ^ ref_h_q;

    // shift register, msb first, filled from bit 0 upward
    logic [W-1:0] shift_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in)
            shift_q <= '0;
        else if (sck_rise)
            shift_q <= {shift_q[W-2:0], data_s};
    end

    // latch follows the shift register while strobe is high
    logic [W-1:0] latch_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in)
            latch_q <= '0;
        else if (stb_s)
            latch_q <= shift_q;
    end

    // first load marks the part programmed; each load starts relock
    logic                    configured_q;
    logic [cfg_loader_pkg::LOCK_W-1:0] lock_cnt_q;
    wire lock_busy = (lock_cnt_q != '0);
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            configured_q <= 1'b0;
            lock_cnt_q   <= '0;
        end else begin
            configured_q <= configured_q | stb_rise;
            if (stb_rise)
                lock_cnt_q <= cfg_loader_pkg::LOCK_W'(LOCK_CYCLES_P);
            else if (lock_busy)
                lock_cnt_q <= lock_cnt_q - 1'b1;
        end
    end

    // field decode from the latch
    wire [11:0] mult_w = {1'b0, latch_q[cfg_loader_pkg::MULT_MSB:
                          cfg_loader_pkg::MULT_LSB]} + 12'h001;
    wire [10:0] div_w  = {1'b0, latch_q[cfg_loader_pkg::DIV_MSB:
                          cfg_loader_pkg::DIV_LSB]} + 11'h001;
    wire [4:0]  adiv_w = latch_q[cfg_loader_pkg::ADIV_MSB:
                                 cfg_loader_pkg::ADIV_LSB];
    wire [4:0]  bdiv_w = latch_q[cfg_loader_pkg::BDIV_MSB:
                                 cfg_loader_pkg::BDIV_LSB];
    wire        ss_w   = latch_q[cfg_loader_pkg::SS_RATE_BIT];

    // per-bank dividers fed by the shared reference edge stream
    wire clk_a_w, clk_b_w;
    bank_divider u_div_a (
        .clk_sys_in   (clk_sys_in),
        .reset_n_in   (reset_n_in),
        .ref_edge_in  (ref_edge),
        .bypass_in    (~configured_q),
        .ref_level_in (ref_s),
        .divide_in    (adiv_w),
        .clk_out      (clk_a_w)
    );
    bank_divider u_div_b (
        .clk_sys_in   (clk_sys_in),
        .reset_n_in   (reset_n_in),
        .ref_edge_in  (ref_edge),
        .bypass_in    (~configured_q),
        .ref_level_in (ref_s),
        .divide_in    (bdiv_w),
        .clk_out      (clk_b_w)
    );

    // registered outputs
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bank_a_clocks_out         <= 4'h0;
            bank_b_clocks_out         <= 4'h0;
            reference_copy_output_out <= 1'b0;
            clocks_oe_out             <= 1'b0;
            pll_mult_out              <= 12'h001;
            pll_div_out               <= 11'h001;
            bank_a_div_out            <= 5'h00;
            bank_b_div_out            <= 5'h00;
            ss_rate_120k_out          <= 1'b0;
            configured_out            <= 1'b0;
            locked_out                <= 1'b0;
        end else begin
            bank_a_clocks_out         <= {4{clk_a_w}};
            bank_b_clocks_out         <= {4{clk_b_w}};
            reference_copy_output_out <= ref_s;
            clocks_oe_out             <= oe_s;
            pll_mult_out              <= mult_w;
            pll_div_out               <= div_w;
            bank_a_div_out            <= adiv_w;
            bank_b_div_out            <= bdiv_w;
            ss_rate_120k_out          <= ss_w;
            configured_out            <= configured_q;
            locked_out                <= ~lock_busy;
        end
    end

    // checks
    property p_shift;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        sck_rise |=> shift_q == {$past(shift_q[W-2:0]), $past(data_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("bad shift");
    property p_transp;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        stb_s |=> latch_q == $past(shift_q);
    endproperty
    a_transp: assert property (p_transp) else $error("latch opaque");
    property p_hold;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !stb_s |=> $stable(latch_q);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved");
    property p_oe;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        oe_s |=> clocks_oe_out;
    endproperty
    a_oe: assert property (p_oe) else $error("oe lost");
    property p_oe_off;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !oe_s |=> !clocks_oe_out;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe stuck");
    property p_default;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !configured_q |=> {bank_a_clocks_out, bank_b_clocks_out}
                          == {8{$past(ref_s)}};
    endproperty
    a_default: assert property (p_default) else $error("no ref");
    property p_relock;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        stb_rise |=> ##1 !locked_out && configured_out;
    endproperty
    a_relock: assert property (p_relock) else $error("no relock");
    property p_count;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        lock_busy && !stb_rise |=> lock_cnt_q == $past(lock_cnt_q) - 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("lock count");
    property p_mult;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ##1 pll_mult_out == $past(mult_w) && pll_div_out == $past(div_w)
            && pll_mult_out != 12'h000 && pll_mult_out <= 12'h800
            && pll_div_out != 11'h000 && pll_div_out <= 11'h400;
    endproperty
    a_mult: assert property (p_mult) else $error("m or n zero");
    property p_ss;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        ##1 ss_rate_120k_out == $past(latch_q[cfg_loader_pkg::SS_RATE_BIT]);
    endproperty
    a_ss: assert property (p_ss) else $error("rate bit");
    c_load: cover property (@(posedge clk_sys_in) stb_rise);
    c_shift_open: cover property (@(posedge clk_sys_in) sck_rise && stb_s);
    c_locked: cover property (@(posedge clk_sys_in)
                              configured_out && locked_out);
endmodule // serial_config_shift_latch

`default_nettype wire

// ---- cfg_loader_pkg.sv ----
// constants for the serial configuration shift and latch block
// What this block does
// - host shifts 160 bits, most significant first
// - strobe high loads latch; relock within 10 ms
// - latch transparent while strobe is high
// - enable high sets clocks_oe_out; clock outputs are always driven
// - unprogrammed part outputs reference on all nine
// - each bank has its own output divider
// - multiplier 1 to 2048, divider 1 to 1024
// - modulation rate choice: 32 kHz or 120 kHz
// - new word applied on the fly, no reset
package cfg_loader_pkg;
    localparam int WORD_BITS    = 160;
    // field positions inside the configuration word
    localparam int MULT_MSB     = 159; // multiplier minus one, 11 bits
    localparam int MULT_LSB     = 149;
    localparam int DIV_MSB      = 148; // divider minus one, 10 bits
    localparam int DIV_LSB      = 139;
    localparam int ADIV_MSB     = 138; // bank a output divide, 5 bits
    localparam int ADIV_LSB     = 134;
    localparam int BDIV_MSB     = 133; // bank b output divide, 5 bits
    localparam int BDIV_LSB     = 129;
    localparam int SS_RATE_BIT  = 128; // 0: 32 kHz, 1: 120 kHz
    // timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int LOCK_TIME_US = 10_000;
    localparam int LOCK_CYCLES  = LOCK_TIME_US * (CLK_HZ / 1_000_000);
    localparam int LOCK_W       = 19;
    // lowest divide the bank dividers apply
    localparam logic [4:0] DIV_MIN = 5'h02;
endpackage

// ---- host_serial_driver.sv ----
// host model that drives the serial configuration pins
`timescale 1ns/1ps
`default_nettype none

module host_serial_driver (
    // system clock used as a time base
    input  wire logic clk_sys_in,
    // serial pins toward the device
    output logic      serial_shift_clock_out,
    output logic      serial_data_out,
    output logic      load_strobe_out
);
    initial begin
        serial_shift_clock_out = 1'b0;
        serial_data_out        = 1'b0;
        load_strobe_out        = 1'b0;
    end

    // wait falling edges of the time base
    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    // one pulse: four cycles low, four high, then one low
    task automatic shift_bit(input logic b);
        serial_data_out = b;
        gap(4);
        serial_shift_clock_out = 1'b1;
        gap(4);
        serial_shift_clock_out = 1'b0;
        serial_data_out        = ~b; // hold over: old bit is gone
        gap(1); // next bit lands a cycle later
    endtask

    // whole word, oldest bit is the msb
    task automatic send_word(input logic [159:0] w);
        load_strobe_out = 1'b0;
        for (int i = 159; i >= 0; i--) shift_bit(w[i]);
    endtask

    // strobe level set by the bench
    task automatic hold_strobe(input logic v);
        load_strobe_out = v;
    endtask
endmodule // host_serial_driver

`default_nettype wire

// ---- serial_config_shift_latch_tb_top.sv ----
// self-checking bench for the serial configuration block
`timescale 1ns/1ps
`default_nettype none

module serial_config_shift_latch_tb_top;
    localparam int LOCK_P  = 20;
    localparam int CEILING = 20000;
    logic        clk_sys_in, reset_n_in, oe, ref_clk, rcp, oe_o, cfg, lck;
    logic        ss;
    logic [3:0]  bka, bkb;
    logic [11:0] mult;
    logic [10:0] div;
    logic [4:0]  adiv, bdiv;
    logic [1:0]  rc;
    wire logic   sck, sd, stb;
    int          n_errors, n_tests, cycles;

    serial_config_shift_latch #(.LOCK_CYCLES_P(LOCK_P)) uut (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .serial_shift_clock_in(sck), .serial_data_in(sd),
        .load_strobe_in(stb), .output_enable_in(oe),
        .reference_in(ref_clk), .bank_a_clocks_out(bka),
        .bank_b_clocks_out(bkb), .reference_copy_output_out(rcp),
        .clocks_oe_out(oe_o), .pll_mult_out(mult), .pll_div_out(div),
        .bank_a_div_out(adiv), .bank_b_div_out(bdiv),
        .ss_rate_120k_out(ss), .configured_out(cfg), .locked_out(lck));

    host_serial_driver host (
        .clk_sys_in(clk_sys_in), .serial_shift_clock_out(sck),
        .serial_data_out(sd), .load_strobe_out(stb));

    // system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    // reference of eight system cycles, cycle counter and timeout
    always @(negedge clk_sys_in) begin
        rc <= rc + 2'h1;
        if (rc == 2'h3) ref_clk <= ~ref_clk;
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == CEILING) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // cycles that bit 0 of a bank stays high after a rise
    task automatic high_time(input logic b, output int n);
        n = 0;
        repeat (400) if ((b ? bkb[0] : bka[0]) === 1'b1) @(negedge clk_sys_in);
        repeat (400) if ((b ? bkb[0] : bka[0]) === 1'b0) @(negedge clk_sys_in);
        while ((b ? bkb[0] : bka[0]) === 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask

    // unprogrammed part copies the reference
    task automatic t_defaults();
        int   nt;
        logic pv;
        nt = 0;
        pv = rcp;
        chk("cfg", 0, cfg);
        chk("mult", 1, mult);
        chk("div", 1, div);
        chk("lock", 1, lck);
        repeat (24) begin
            @(negedge clk_sys_in);
            chk("bank_a", {4{rcp}}, bka);
            chk("bank_b", {4{rcp}}, bkb);
            if (rcp !== pv) nt++;
            pv = rcp;
        end
        chk("ref_toggles", 6, nt);
    endtask

    // reset in mid-run returns the part to its unprogrammed state
    task automatic t_reset();
        reset_n_in = 1'b0;
        host.gap(2);
        chk("cfg_rst", 0, cfg);
        reset_n_in = 1'b1;
        host.gap(4);
        t_defaults();
    endtask

    // shift a word, load it, time the relock, check fields
    task automatic t_load(input int m, n, a, b, input logic r);
        logic [159:0] w;
        int           lo, h;
        w = {11'(m - 1), 10'(n - 1), 5'(a), 5'(b), r, {4{32'h5a3c96e1}}};
        host.send_word(w);
        host.hold_strobe(1'b1);
        lo = 0;
        for (int i = 0; i < LOCK_P + 12; i++) begin
            @(negedge clk_sys_in);
            if (i == 4) host.hold_strobe(1'b0);
            if (lck === 1'b0) lo++;
        end
        chk("lock_low", 1, lo >= LOCK_P && lo <= LOCK_P + 2);
        chk("cfg", 1, cfg);
        chk("mult", m, mult);
        chk("div", n, div);
        chk("adiv", a, adiv);
        chk("bdiv", b, bdiv);
        chk("ss", r, ss);
        high_time(1'b0, h);
        chk("a_high", a * 4, h);
        high_time(1'b1, h);
        chk("b_high", b * 4, h);
    endtask

    // shifting with strobe high reaches the latch at once
    task automatic t_transparent();
        host.hold_strobe(1'b1);
        host.shift_bit(1'b1);
        host.gap(4);
        chk("mult_live", 12'h002, mult);
        chk("div_live", 11'h001, div);
        host.hold_strobe(1'b0);
        host.gap(LOCK_P + 8);
    endtask

    // enable low clears clocks_oe_out; the nine clock pins keep driving
    task automatic t_enable();
        oe = 1'b0;
        host.gap(5);
        chk("oe_low", 0, oe_o);
        oe = 1'b1;
        host.gap(5);
        chk("oe_high", 1, oe_o);
    endtask

    initial begin
        reset_n_in = 1'b0;
        oe         = 1'b1;
        ref_clk    = 1'b0;
        rc         = 2'h0;
        n_errors   = 0;
        n_tests    = 0;
        cycles     = 0;
        repeat (4) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        host.gap(4);
        t_defaults();
        t_enable();
        t_load(2048, 1024, 20, 3, 1'b1);
        t_load(1, 513, 2, 5, 1'b0);
        t_transparent();
        t_reset();
        end_of_test();
    end
endmodule // serial_config_shift_latch_tb_top

`default_nettype wire
